// ---- verilog/ac_link_pkg.sv ----
// Constants shared by the sixteen-bit-slot input frame transmitter.
package ac_link_pkg;

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam int SLOT_BITS  = 16;
	localparam int NUM_SLOTS  = 16;
	localparam int FRAME_BITS = SLOT_BITS * NUM_SLOTS;

	localparam int TAG_READY_BIT   = 15;
	localparam int TAG_ZERO_HI_BIT = 14;
	localparam int TAG_ZERO_LO_BIT = 13;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS      = 8'h00;
	localparam logic [7:0] STATUS_OFS    = 8'h04;
	localparam logic [7:0] VALID_OFS     = 8'h08;
	localparam logic [1:0] SLOT_PAGE     = 2'h1;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int CTRL_W          = 6;
	localparam int CTRL_SLOT16_BIT = 0;
	localparam int CTRL_REGS_OK_BIT = 1;
	localparam int CTRL_SUBSYS_LSB = 2;
	localparam int CTRL_SUBSYS_W   = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

	// ------------------------------------------------------------
	// Status register fields
	// ------------------------------------------------------------
	localparam int STATUS_READY_BIT  = 0;
	localparam int STATUS_LINK_BIT   = 1;
	localparam int STATUS_ACTIVE_BIT = 2;
	localparam int STATUS_COUNT_LSB  = 16;

	localparam int VALID_W = NUM_SLOTS - 1;
	localparam logic [VALID_W-1:0] VALID_RESET = 15'h0000;

endpackage

// ---- verilog/ac_link_input_frame.sv ----
// Codec side of the sixteen-bit-slot input frame with its Avalon-MM register file.
`timescale 1ns/1ps
// Overview of operation
// - Each input frame is one 16-bit tag slot then fifteen 16-bit data slots.
// - In sixteen-bit-slot mode tag bits 13 and 14 go out as zero.
// - Frame sync is looked at on every bit clock falling edge, also mid-frame.
// - Frame starts on sync rising, caught at the next bit clock falling edge.
// - Next bit clock rising edge puts tag bit 15, codec ready, on the line.
// - Each bit leaves on a rising edge; controller samples on the falling edge.
// - Stream is MSB first; every non-valid bit position is sent as zero.
// - Codec ready reads zero while the codec is not ready for operation.
// - Ready only with link, control registers and at least one subsystem operational.
// - Once ready, tag bits below bit 15 flag validity of slots one to fifteen.
// - Both sides shift MSB first; core clock must exceed the bit clock.
module ac_link_input_frame
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        bit_clk,
	input  wire logic        frame_sync,
	output logic             serial_data_to_controller
);

	// ------------------------------------------------------------
	// Pin synchronisers and bit clock edges
	// ------------------------------------------------------------
	logic bclk_meta_reg;
	logic bclk_sync_reg;
	logic bclk_prev_reg;
	logic sync_meta_reg;
	logic sync_sync_reg;
	logic sync_at_fall_reg;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bclk_meta_reg <= 1'b0;
			bclk_sync_reg <= 1'b0;
			bclk_prev_reg <= 1'b0;
			sync_meta_reg <= 1'b0;
			sync_sync_reg <= 1'b0;
		end
		else
		begin
			bclk_meta_reg <= bit_clk;
			bclk_sync_reg <= bclk_meta_reg;
			bclk_prev_reg <= bclk_sync_reg;
			sync_meta_reg <= frame_sync;
			sync_sync_reg <= sync_meta_reg;
		end
	end

	wire bclk_rise = bclk_sync_reg & ~bclk_prev_reg;
	wire bclk_fall = ~bclk_sync_reg & bclk_prev_reg;

	// ------------------------------------------------------------
	// Frame start detection
	// ------------------------------------------------------------
	// Sync is only sampled on falling edges, so a one-bit pulse is enough.
	wire sync_rise_seen = bclk_fall & sync_sync_reg & ~sync_at_fall_reg;
	logic start_pending_reg;
	logic link_up_reg;
	wire  load_tag = bclk_rise & start_pending_reg;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync_at_fall_reg  <= 1'b0;
			start_pending_reg <= 1'b0;
			link_up_reg       <= 1'b0;
		end
		else
		begin
			if (bclk_fall)
				sync_at_fall_reg <= sync_sync_reg;
			if (sync_rise_seen)
				start_pending_reg <= 1'b1;
			else if (bclk_rise)
				start_pending_reg <= 1'b0;
			if (sync_rise_seen)
				link_up_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Register file state
	// ------------------------------------------------------------
	logic [ac_link_pkg::CTRL_W-1:0]    ctrl_reg;
	logic [ac_link_pkg::VALID_W-1:0]   valid_reg;
	logic [ac_link_pkg::SLOT_BITS-1:0] slot_data_mem [0:ac_link_pkg::VALID_W-1];
	logic [15:0]                       frame_cnt_reg;

	wire slot16_mode = ctrl_reg[ac_link_pkg::CTRL_SLOT16_BIT];
	wire regs_ok     = ctrl_reg[ac_link_pkg::CTRL_REGS_OK_BIT];
	wire subsys_any  = |ctrl_reg[ac_link_pkg::CTRL_SUBSYS_LSB +: ac_link_pkg::CTRL_SUBSYS_W];

	// Ready needs a live link, working registers and at least one subsystem.
	wire codec_ready = link_up_reg & regs_ok & subsys_any;

	// ------------------------------------------------------------
	// Tag word
	// ------------------------------------------------------------
	logic [ac_link_pkg::VALID_W-1:0] tag_valid;

	for (genvar n = 1; n < ac_link_pkg::NUM_SLOTS; n++)
	begin : g_tag
		assign tag_valid[ac_link_pkg::VALID_W-n] = valid_reg[n-1];
	end

	wire [ac_link_pkg::VALID_W-1:0] tag_zero_mask =
		slot16_mode ? 15'h1fff : 15'h7fff;
	wire [ac_link_pkg::VALID_W-1:0] tag_flags =
		codec_ready ? (tag_valid & tag_zero_mask) : 15'h0000;
	wire [ac_link_pkg::SLOT_BITS-1:0] tag_word = {codec_ready, tag_flags};

	// ------------------------------------------------------------
	// Serial transmitter
	// ------------------------------------------------------------
	logic                              active_reg;
	logic [7:0]                        bit_cnt_reg;
	logic [ac_link_pkg::SLOT_BITS-1:0] shift_reg;
	logic                              sdata_reg;
	logic                              slot_valid_reg;
	logic                              ready_frame_reg;
	logic                              slot16_frame_reg;
	logic [ac_link_pkg::VALID_W-1:0]   valid_frame_reg;

	logic                              active_next;
	logic [7:0]                        bit_cnt_next;
	logic [ac_link_pkg::SLOT_BITS-1:0] shift_next;
	logic                              sdata_next;
	logic                              slot_valid_next;

	wire       last_bit   = bit_cnt_reg == 8'(ac_link_pkg::FRAME_BITS - 1);
	wire       slot_end   = bit_cnt_reg[3:0] == 4'hf;
	wire [3:0] next_index = bit_cnt_reg[7:4];
	wire       next_valid = ready_frame_reg & valid_frame_reg[next_index];

	// Invalid slots are stuffed with zero rather than stale memory contents.
	wire [ac_link_pkg::SLOT_BITS-1:0] next_word =
		next_valid ? slot_data_mem[next_index] : 16'h0000;

	always_comb
	begin
		active_next     = active_reg;
		bit_cnt_next    = bit_cnt_reg;
		shift_next      = shift_reg;
		sdata_next      = sdata_reg;
		slot_valid_next = slot_valid_reg;
		if (load_tag)
		begin
			active_next     = 1'b1;
			bit_cnt_next    = 8'h00;
			sdata_next      = tag_word[ac_link_pkg::TAG_READY_BIT];
			shift_next      = {tag_word[14:0], 1'b0};
			slot_valid_next = 1'b1;
		end
		else if (bclk_rise && active_reg)
		begin
			if (last_bit)
			begin
				active_next     = 1'b0;
				sdata_next      = 1'b0;
				shift_next      = 16'h0000;
				slot_valid_next = 1'b0;
			end
			else
			begin
				bit_cnt_next = bit_cnt_reg + 8'h01;
				if (slot_end)
				begin
					sdata_next      = next_word[15];
					shift_next      = {next_word[14:0], 1'b0};
					slot_valid_next = next_valid;
				end
				else
				begin
					sdata_next = shift_reg[15];
					shift_next = {shift_reg[14:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			active_reg     <= 1'b0;
			bit_cnt_reg    <= 8'h00;
			shift_reg      <= 16'h0000;
			sdata_reg      <= 1'b0;
			slot_valid_reg <= 1'b0;
		end
		else
		begin
			active_reg     <= active_next;
			bit_cnt_reg    <= bit_cnt_next;
			shift_reg      <= shift_next;
			sdata_reg      <= sdata_next;
			slot_valid_reg <= slot_valid_next;
		end
	end

	// The frame keeps the settings seen at its start so a control or valid write cannot tear it; slot data is read at each slot start.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ready_frame_reg  <= 1'b0;
			slot16_frame_reg <= 1'b0;
			valid_frame_reg  <= ac_link_pkg::VALID_RESET;
			frame_cnt_reg    <= 16'h0000;
		end
		else if (load_tag)
		begin
			ready_frame_reg  <= codec_ready;
			slot16_frame_reg <= slot16_mode;
			// Slots whose tag bit is forced low must also go out as zero.
			valid_frame_reg  <= valid_reg & ~{13'h0000, {2{slot16_mode}}};
			frame_cnt_reg    <= frame_cnt_reg + 16'h0001;
		end
	end

	assign serial_data_to_controller = sdata_reg;

	// ------------------------------------------------------------
	// Avalon-MM slave
	// ------------------------------------------------------------
	logic ack_reg;
	logic wait_reg;
	logic [31:0] readdata_reg;

	wire request = read | write;
	wire ack_next = request & ~ack_reg;
	wire wr_en = write & ack_reg;
	wire rd_take = read & ~ack_reg;

	wire sel_ctrl   = address == ac_link_pkg::CTRL_OFS;
	wire sel_status = address == ac_link_pkg::STATUS_OFS;
	wire sel_valid  = address == ac_link_pkg::VALID_OFS;
	wire sel_slot   = (address[7:6] == ac_link_pkg::SLOT_PAGE) &&
		(address[5:2] != 4'h0) && (address[1:0] == 2'h0);
	wire [3:0] slot_ix = address[5:2] - 4'h1;

	wire [31:0] be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
		{8{byteenable[1]}}, {8{byteenable[0]}}};
	wire [31:0] ctrl_merge = ({26'h0, ctrl_reg} & ~be_mask) | (writedata & be_mask);
	wire [31:0] valid_merge = ({17'h0, valid_reg} & ~be_mask) | (writedata & be_mask);
	wire [31:0] slot_merge = ({16'h0, slot_data_mem[slot_ix]} & ~be_mask) |
		(writedata & be_mask);

	wire [31:0] status_word = {frame_cnt_reg, 13'h0, active_reg, link_up_reg, codec_ready};
	wire [31:0] rd_mux =
		sel_ctrl   ? {26'h0, ctrl_reg} :
		sel_status ? status_word :
		sel_valid  ? {17'h0, valid_reg} :
		sel_slot   ? {16'h0, slot_data_mem[slot_ix]} :
		32'h0000_0000;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ack_reg      <= 1'b0;
			wait_reg     <= 1'b1;
			readdata_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg  <= ack_next;
			wait_reg <= ~ack_next;
			if (rd_take)
				readdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_reg  <= ac_link_pkg::CTRL_RESET;
			valid_reg <= ac_link_pkg::VALID_RESET;
		end
		else if (wr_en)
		begin
			if (sel_ctrl)
				ctrl_reg <= ctrl_merge[ac_link_pkg::CTRL_W-1:0];
			if (sel_valid)
				valid_reg <= valid_merge[ac_link_pkg::VALID_W-1:0];
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < ac_link_pkg::VALID_W; i++)
				slot_data_mem[i] <= 16'h0000;
		end
		else if (wr_en && sel_slot)
			slot_data_mem[slot_ix] <= slot_merge[15:0];
	end

	assign readdata    = readdata_reg;
	assign waitrequest = wait_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_sync_catch: assert property (
		bclk_fall && sync_sync_reg && !sync_at_fall_reg |=> start_pending_reg)
		else $error("Frame sync rise was not caught.");
	a_frame_start: assert property (
		start_pending_reg && bclk_rise |=> active_reg && bit_cnt_reg == 8'h00)
		else $error("Frame did not start on the bit clock rise.");
	a_tag_msb_ready: assert property (
		load_tag |=> sdata_reg == $past(codec_ready))
		else $error("Tag MSB does not carry codec ready.");
	a_tag_zero_bits: assert property (
		active_reg && slot16_frame_reg && (bit_cnt_reg == 8'h01 || bit_cnt_reg == 8'h02)
		|-> !sdata_reg)
		else $error("Tag bits 14 or 13 not zero in slot16 mode.");
	a_notready_zero: assert property (
		active_reg && !ready_frame_reg |-> !sdata_reg)
		else $error("Data sent while codec not ready.");
	a_invalid_slot_zero: assert property (
		active_reg && !slot_valid_reg |-> !sdata_reg)
		else $error("Invalid slot carries a one.");
	a_shift_on_rise: assert property (
		$changed(sdata_reg) |-> $past(bclk_rise))
		else $error("Serial data changed without a bit clock rise.");
	a_frame_length: assert property (
		active_reg && last_bit && bclk_rise && !start_pending_reg |=> !active_reg)
		else $error("Frame did not end after 256 bits.");
	a_ready_gate: assert property (
		load_tag && !(regs_ok && subsys_any) |=> !sdata_reg)
		else $error("Ready sent without operational subsystems.");
	a_bus_answer: assert property (
		request && wait_reg |=> !wait_reg ##1 wait_reg)
		else $error("Bus answer not one cycle after request.");

	c_ready_frame: cover property (load_tag && codec_ready);
	c_frame_done: cover property (active_reg && last_bit && bclk_rise);
	c_valid_write: cover property (wr_en && sel_valid);
	c_resync: cover property (sync_rise_seen && active_reg);

endmodule

// ---- verification/link_controller_model.sv ----
// Controller-side model: makes the link clock and frame sync, captures input frames.
`timescale 1ns/1ps
module link_controller_model
(
	input  wire logic         en,
	input  wire logic         sdata,
	output logic              bit_clk,
	output logic              frame_sync,
	output logic      [255:0] frame_bits,
	output logic              frame_done
);
	logic [7:0]   div_reg;
	logic [255:0] shift_reg;
	int           bit_count;
	logic         active;

	// ------------------------------------------------------------
	// Link clock and frame sync
	// ------------------------------------------------------------
	// The phase offset keeps link clock edges off the system clock edges.
	initial
	begin
		bit_clk = 1'b0;
		frame_sync = 1'b0;
		frame_done = 1'b0;
		div_reg = 8'h00;
		active = 1'b0;
		bit_count = 0;
		#13;
		forever #40 bit_clk = ~bit_clk;
	end

	// One-period sync pulse every 256 bit clocks, launched on a rising edge.
	always @(posedge bit_clk)
	begin
		div_reg <= en ? div_reg + 8'h01 : 8'h00;
		frame_sync <= en && div_reg == 8'hff;
	end

	// ------------------------------------------------------------
	// Capture
	// ------------------------------------------------------------
	// Bits are taken on falling edges, MSB first, counted from each sync.
	always @(negedge bit_clk)
	begin
		frame_done <= 1'b0;
		if (active)
		begin
			shift_reg = {shift_reg[254:0], sdata};
			bit_count++;
			if (bit_count == 256)
			begin
				frame_bits = shift_reg;
				frame_done <= 1'b1;
				active = 1'b0;
			end
		end
		if (frame_sync)
		begin
			active = 1'b1;
			bit_count = 0;
		end
	end
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the input frame block and its register file.
`timescale 1ns/1ps
module testbench;
	logic         clk;
	logic         sys_rst;
	logic [7:0]   address;
	logic         read;
	logic         write;
	logic [31:0]  writedata;
	logic [3:0]   byteenable;
	logic [31:0]  readdata;
	logic         waitrequest;
	logic         bit_clk;
	logic         frame_sync;
	logic         sdata;
	logic         en;
	logic [255:0] frame_bits;
	logic         frame_done;
	int           mismatches;
	int           n_compared;
	int           cycles;
	int           i;
	int           n;
	integer       seed;
	logic [63:0]  read_notes [$];
	logic [256:0] frame_notes [$];
	logic [63:0]  rnote;
	logic [256:0] fnote;
	logic [5:0]   ctrl_table [7];
	logic [15:0]  slot_data [16];
	logic [5:0]   ctrl;
	logic [14:0]  valid;
	logic [15:0]  tag;
	logic         rdy;
	logic [255:0] expf;

	ac_link_input_frame dut
	(
		.clk                       (clk),
		.sys_rst                   (sys_rst),
		.address                   (address),
		.read                      (read),
		.write                     (write),
		.writedata                 (writedata),
		.byteenable                (byteenable),
		.readdata                  (readdata),
		.waitrequest               (waitrequest),
		.bit_clk                   (bit_clk),
		.frame_sync                (frame_sync),
		.serial_data_to_controller (sdata)
	);

	link_controller_model partner
	(
		.en         (en),
		.sdata      (sdata),
		.bit_clk    (bit_clk),
		.frame_sync (frame_sync),
		.frame_bits (frame_bits),
		.frame_done (frame_done)
	);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task give_verdict;
		begin
			if (mismatches == 0 && n_compared > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask

	// ------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------
	// The request is held until waitrequest is seen low at a rising edge.
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		int k;
		begin
			k = 0;
			address <= a;
			writedata <= d;
			byteenable <= be;
			read <= ~wr;
			write <= wr;
			@(posedge clk);
			while (waitrequest !== 1'b0 && k < 20)
			begin
				@(posedge clk);
				k++;
			end
			if (k >= 20)
			begin
				mismatches++;
				$display("mismatch at %0t: no bus answer", $time);
			end
			read <= 1'b0;
			write <= 1'b0;
			@(posedge clk);
		end
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		begin
			read_notes.push_back({m, e});
			bus(1'b0, a, 32'h0, 4'hf);
		end
	endtask

	// A skipped frame is one whose contents straddle a reconfiguration.
	task frame(input logic skip, input logic [255:0] e);
		begin
			frame_notes.push_back({skip, e});
			@(posedge frame_done);
			@(posedge clk);
		end
	endtask

	// ------------------------------------------------------------
	// Monitors
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		cycles++;
		if (read === 1'b1 && waitrequest === 1'b0 && read_notes.size() > 0)
		begin
			rnote = read_notes.pop_front();
			n_compared++;
			if ((readdata & rnote[63:32]) !== rnote[31:0])
			begin
				mismatches++;
				$display("mismatch at %0t: read %h at %h", $time, readdata, address);
			end
		end
		if (cycles == 60000)
		begin
			mismatches++;
			$display("mismatch at %0t: timeout", $time);
			give_verdict;
		end
	end

	always @(posedge frame_done)
	begin
		if (frame_notes.size() > 0)
		begin
			fnote = frame_notes.pop_front();
			if (!fnote[256])
			begin
				n_compared++;
				if ((frame_bits[255:240] & 16'h8000) !== (fnote[255:240] & 16'h8000))
				begin
					mismatches++;
					$display("mismatch at %0t: codec ready flag", $time);
				end
				n_compared++;
				if (frame_bits !== fnote[255:0])
				begin
					mismatches++;
					$display("mismatch at %0t: frame %h", $time, frame_bits);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		seed = 32'h038bb315;
		sys_rst = 1'b1;
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'hf;
		en = 1'b0;
		mismatches = 0;
		n_compared = 0;
		ctrl_table = '{6'h02, 6'h3c, 6'h07, 6'h0b, 6'h13, 6'h23, 6'h3e};
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rd(ac_link_pkg::CTRL_OFS, 32'h0, 32'hffffffff);
		rd(ac_link_pkg::STATUS_OFS, 32'h0, 32'hffffffff);
		rd(ac_link_pkg::VALID_OFS, 32'h0, 32'hffffffff);
		rd(8'h44, 32'h0, 32'hffffffff);
		rd(8'h7c, 32'h0, 32'hffffffff);
		bus(1'b1, 8'h0c, 32'hffffffff, 4'hf);
		rd(8'h0c, 32'h0, 32'hffffffff);
		bus(1'b1, ac_link_pkg::STATUS_OFS, 32'hffffffff, 4'hf);
		rd(ac_link_pkg::STATUS_OFS, 32'h0, 32'h7);
		bus(1'b1, ac_link_pkg::VALID_OFS, 32'hffffffff, 4'h2);
		rd(ac_link_pkg::VALID_OFS, 32'h7f00, 32'hffffffff);
		en <= 1'b1;
		frame(1'b1, 256'h0);
		for (i = 0; i < 7; i++)
		begin
			ctrl = ctrl_table[i];
			valid = 15'($random(seed));
			bus(1'b1, ac_link_pkg::CTRL_OFS, {26'h0, ctrl}, 4'hf);
			rd(ac_link_pkg::CTRL_OFS, {26'h0, ctrl}, 32'hffffffff);
			bus(1'b1, ac_link_pkg::VALID_OFS, {17'h0, valid}, 4'hf);
			rdy = ctrl[1] & (|ctrl[5:2]);
			tag = {rdy, 15'h0000};
			for (n = 1; n < 16; n++)
				tag[15 - n] = valid[n - 1];
			if (ctrl[0])
				tag[14:13] = 2'b00;
			expf = 256'h0;
			expf[255:240] = rdy ? tag : 16'h0;
			for (n = 1; n < 16; n++)
			begin
				slot_data[n] = 16'($random(seed));
				bus(1'b1, 8'(8'h40 + 4 * n), {16'h0, slot_data[n]}, 4'hf);
				if (rdy && tag[15 - n])
					expf[255 - 16 * n -: 16] = slot_data[n];
			end
			frame(1'b1, 256'h0);
			rd(ac_link_pkg::STATUS_OFS, {30'h0, 1'b1, rdy}, 32'h3);
			rd(8'h7c, {16'h0, slot_data[15]}, 32'hffffffff);
			frame(1'b0, expf);
		end
		give_verdict;
	end
endmodule
